// file: shared/ret_ctrl_pkg.sv
`default_nettype none
package ret_ctrl_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned IW      = 14;
   localparam int unsigned PCW     = 13;
   localparam int unsigned DW      = 8;
   localparam int unsigned SPW     = 3;
   localparam int unsigned DEPTH   = 8;
   localparam int unsigned GIE_BIT = 7;

   // ------------------------------------------------------------
   // Opcode patterns as mask and match
   // ------------------------------------------------------------
   localparam logic [IW-1:0] NOP_MASK = 14'h3F9F;
   localparam logic [IW-1:0] NOP_VAL  = 14'h0000;
   localparam logic [IW-1:0] FULL_MASK = 14'h3FFF;
   localparam logic [IW-1:0] RETI_VAL = 14'h0009;
   localparam logic [IW-1:0] RET_VAL  = 14'h0008;
   localparam logic [IW-1:0] OPT_VAL  = 14'h0062;
   localparam logic [IW-1:0] LIT_MASK = 14'h3C00;
   localparam logic [IW-1:0] LIT_VAL  = 14'h3400;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [SPW-1:0] SP_RST      = 3'h0;
   localparam logic [PCW-1:0] PC_RST      = 13'h0000;
   localparam logic [DW-1:0]  DATA_RST    = 8'h00;
   localparam logic [IW-1:0]  IR_RST      = 14'h0000;
   localparam logic [DW-1:0]  GIE_MASK    = 8'h80;
   localparam int unsigned    PHASES      = 4;
   localparam logic [2:0]     IDLE_CNT_RST = 3'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PH_Q1 = 2'h0,
      PH_Q2 = 2'h1,
      PH_Q3 = 2'h3,
      PH_Q4 = 2'h2
   } phase_t;

   typedef enum logic
   {
      CYC_FIRST = 1'h0,
      CYC_IDLE  = 1'h1
   } cyc_t;

   typedef enum logic [2:0]
   {
      CL_OTHER = 3'h0,
      CL_NOP   = 3'h1,
      CL_RETI  = 3'h2,
      CL_RET   = 3'h3,
      CL_LIT   = 3'h4,
      CL_OPT   = 3'h5
   } cls_t;

   typedef struct packed
   {
      logic          we;
      logic [DW-1:0] data;
   } wr8_t;

   typedef struct packed
   {
      logic           load;
      logic [PCW-1:0] addr;
   } pc_wr_t;
endpackage
`default_nettype wire

// file: hw/ret_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ret_stack_mem
   import ret_ctrl_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           ce,
   input  wire logic           wr_en,
   input  wire logic [SPW-1:0] wr_addr,
   input  wire logic [PCW-1:0] wr_data,
   input  wire logic [SPW-1:0] rd_addr,
   output logic      [PCW-1:0] rd_data
);
   logic [PCW-1:0] mem [DEPTH];

   // ------------------------------------------------------------
   // One write-enabled register per entry
   // ------------------------------------------------------------
   // Cleared on reset so a pop of an unused entry reads zero, not unknown
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge clk)
         begin
            if (rst)
               mem[gi] <= PC_RST;
            else if (ce && wr_en && (wr_addr == SPW'(gi)))
               mem[gi] <= wr_data;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Registered read port
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
         rd_data <= PC_RST;
      else if (ce)
         rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// file: hw/return_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Idle instruction matched with two don't-care bits; it writes nothing.
// RULE2: Idle instruction lasts one cycle: decode then three idle phases.
// RULE3: Interrupt return pops the stack and loads the head into the counter.
// RULE4: Interrupt return sets global_irq_enable, bit 7, in phase three of cycle one.
// RULE5: Interrupt return takes two cycles; pop in phase four, second cycle idle.
// RULE6: Option load copies the accumulator into the option register in one cycle.
// RULE7: Literal return writes the literal to the accumulator and reloads the counter.
// RULE8: Literal return takes two cycles; writes and pop in the first, then idle.
// RULE9: Subroutine return pops the stack into the counter, touching no flag.
// RULE10: Subroutine return takes two cycles; the second refills the pipeline.
// RULE11: The prefetched word is discarded during the second cycle of any return.
module return_ctrl
   import ret_ctrl_pkg::*;
(
   input  wire logic          CLK_SYS,
   input  wire logic          RST,
   input  wire logic          CE,
   input  wire logic          INSTR_VALID,
   input  wire logic [IW-1:0] INSTR,
   input  wire logic [DW-1:0] W_IN,
   input  wire pc_wr_t        PUSH,
   output logic               FETCH_TAKE,
   output logic               FLUSH_PREFETCH,
   output logic [1:0]         PHASE,
   output var wr8_t           W_WR,
   output var wr8_t           OPT_WR,
   output var pc_wr_t         PC_WR,
   output logic [DW-1:0]      IRQ_CTRL_SET,
   output logic [SPW-1:0]     STACK_PTR
);
   phase_t         phase_r;
   phase_t         phase_nxt;
   cyc_t           cyc_r;
   cls_t           cls_r;
   logic [IW-1:0]  ir_r;
   logic [SPW-1:0] sp_r;
   logic [SPW-1:0] head_addr;
   logic [PCW-1:0] head_data;
   logic           is_return;
   logic           two_cycle;
   logic           push_go;
   logic           pop_go;
   logic           w_we_r;
   logic [DW-1:0]  w_data_r;
   logic           opt_we_r;
   logic [DW-1:0]  opt_data_r;
   logic           pc_load_r;
   logic [PCW-1:0] pc_val_r;
   logic           gie_set_r;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic cls_t classify(input logic [IW-1:0] op);
      cls_t c;
      c = CL_OTHER;
      if ((op & NOP_MASK) == NOP_VAL)
         c = CL_NOP;
      else if ((op & FULL_MASK) == RETI_VAL)
         c = CL_RETI;
      else if ((op & FULL_MASK) == RET_VAL)
         c = CL_RET;
      else if ((op & FULL_MASK) == OPT_VAL)
         c = CL_OPT;
      else if ((op & LIT_MASK) == LIT_VAL)
         c = CL_LIT;
      return c;
   endfunction

   assign is_return = (cls_r == CL_RETI) || (cls_r == CL_RET) || (cls_r == CL_LIT);
   assign two_cycle = is_return && (cyc_r == CYC_FIRST);
   assign pop_go    = two_cycle && (phase_r == PH_Q4);
   // Pushes from call logic only land outside a pop so the pointer moves once
   assign push_go   = PUSH.load && !pop_go && (phase_r == PH_Q4);
   assign head_addr = sp_r - 3'h1;

   // ------------------------------------------------------------
   // Phase counter
   // ------------------------------------------------------------
   always_comb
   begin
      case (phase_r)
         PH_Q1:   phase_nxt = PH_Q2;
         PH_Q2:   phase_nxt = PH_Q3;
         PH_Q3:   phase_nxt = PH_Q4;
         PH_Q4:   phase_nxt = PH_Q1;
         default: phase_nxt = PH_Q1;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         phase_r <= PH_Q1;
      else if (CE)
         phase_r <= phase_nxt;
   end

   // ------------------------------------------------------------
   // Instruction latch at end of decode phase
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         ir_r  <= IR_RST;
         cls_r <= CL_NOP;
      end
      else if (CE && FETCH_TAKE)
      begin
         // Missing word runs as the idle instruction
         ir_r  <= INSTR_VALID ? INSTR : IR_RST;
         cls_r <= INSTR_VALID ? classify(INSTR) : CL_NOP; // [RULE1]
      end
   end

   // ------------------------------------------------------------
   // Cycle sequencing
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         cyc_r <= CYC_FIRST;
      else if (CE && (phase_r == PH_Q4))
      begin
         case (cyc_r)
            CYC_FIRST: cyc_r <= is_return ? CYC_IDLE : CYC_FIRST; // [RULE2] [RULE5] [RULE8] [RULE10]
            CYC_IDLE:  cyc_r <= CYC_FIRST;
            default:   cyc_r <= CYC_FIRST;
         endcase
      end
   end

   // Nothing is taken in the idle cycle, so the stale prefetch dies here
   assign FETCH_TAKE     = (phase_r == PH_Q1) && (cyc_r == CYC_FIRST); // [RULE11]
   assign FLUSH_PREFETCH = (cyc_r == CYC_IDLE); // [RULE11]

   // ------------------------------------------------------------
   // Stack pointer and memory
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         sp_r <= SP_RST;
      else if (CE && pop_go)
         sp_r <= head_addr; // [RULE3] [RULE9]
      else if (CE && push_go)
         sp_r <= sp_r + 3'h1;
   end

   ret_stack_mem u_stack
   (
      .clk     (CLK_SYS),
      .rst     (RST),
      .ce      (CE),
      .wr_en   (CE && push_go),
      .wr_addr (sp_r),
      .wr_data (PUSH.addr),
      .rd_addr (head_addr),
      .rd_data (head_data)
   );

   // ------------------------------------------------------------
   // Counter reload, valid during phase four
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         pc_load_r <= 1'b0;
         pc_val_r  <= PC_RST;
      end
      else if (CE)
      begin
         pc_load_r <= two_cycle && (phase_r == PH_Q3); // [RULE3] [RULE7] [RULE9]
         if (two_cycle && (phase_r == PH_Q3))
            pc_val_r <= head_data;
      end
   end

   // ------------------------------------------------------------
   // Interrupt enable set, valid during phase three
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         gie_set_r <= 1'b0;
      else if (CE)
         gie_set_r <= (cls_r == CL_RETI) && (cyc_r == CYC_FIRST) && (phase_r == PH_Q2); // [RULE4]
   end

   // ------------------------------------------------------------
   // Accumulator and option writes, valid during phase four
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         w_we_r   <= 1'b0;
         w_data_r <= DATA_RST;
      end
      else if (CE)
      begin
         w_we_r <= (cls_r == CL_LIT) && (cyc_r == CYC_FIRST) && (phase_r == PH_Q3); // [RULE7]
         if ((cls_r == CL_LIT) && (phase_r == PH_Q3))
            w_data_r <= ir_r[DW-1:0]; // [RULE7]
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         opt_we_r   <= 1'b0;
         opt_data_r <= DATA_RST;
      end
      else if (CE)
      begin
         // Status flags have no path from here; only the option copy moves
         opt_we_r <= (cls_r == CL_OPT) && (phase_r == PH_Q3); // [RULE6]
         if ((cls_r == CL_OPT) && (phase_r == PH_Q3))
            opt_data_r <= W_IN; // [RULE6]
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign PHASE        = phase_r;
   assign W_WR         = '{we: w_we_r, data: w_data_r};
   assign OPT_WR       = '{we: opt_we_r, data: opt_data_r};
   assign PC_WR        = '{load: pc_load_r, addr: pc_val_r};
   assign IRQ_CTRL_SET = gie_set_r ? GIE_MASK : DATA_RST;
   assign STACK_PTR    = sp_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [2:0] idle_cnt_r;

   always_ff @(posedge CLK_SYS)
   begin
      if (RST)
         idle_cnt_r <= IDLE_CNT_RST;
      else if (CE)
         idle_cnt_r <= (cyc_r == CYC_IDLE) ? idle_cnt_r + 3'h1 : IDLE_CNT_RST;
   end

   chk_nop_no_write: assert property ( // [RULE1]
      @(posedge CLK_SYS) disable iff (RST)
      (cls_r == CL_NOP) |-> !(w_we_r || opt_we_r || pc_load_r || gie_set_r))
      else $error("idle instruction caused a write");

   chk_nop_one_cycle: assert property ( // [RULE2]
      @(posedge CLK_SYS) disable iff (RST)
      (CE && cls_r == CL_NOP && cyc_r == CYC_FIRST && phase_r == PH_Q4)
      |=> (cyc_r == CYC_FIRST && phase_r == PH_Q1))
      else $error("idle instruction exceeded one cycle");

   chk_ret_head_load: assert property ( // [RULE3]
      @(posedge CLK_SYS) disable iff (RST)
      (CE && two_cycle && phase_r == PH_Q3)
      |=> (pc_load_r && pc_val_r == $past(head_data) && phase_r == PH_Q4))
      else $error("return did not load stack head");

   chk_gie_phase_three: assert property ( // [RULE4]
      @(posedge CLK_SYS) disable iff (RST)
      (IRQ_CTRL_SET != DATA_RST)
      |-> (IRQ_CTRL_SET == GIE_MASK && phase_r == PH_Q3 && cls_r == CL_RETI
           && cyc_r == CYC_FIRST))
      else $error("interrupt enable set out of place");

   chk_reti_two_cycle: assert property ( // [RULE5]
      @(posedge CLK_SYS) disable iff (RST)
      (CE && cls_r == CL_RETI && cyc_r == CYC_FIRST && phase_r == PH_Q4)
      |=> (cyc_r == CYC_IDLE && sp_r == $past(sp_r) - 3'h1))
      else $error("interrupt return missed its idle cycle or pop");

   chk_option_copy: assert property ( // [RULE6]
      @(posedge CLK_SYS) disable iff (RST)
      (CE && cls_r == CL_OPT && phase_r == PH_Q3)
      |=> (opt_we_r && opt_data_r == $past(W_IN) && !pc_load_r))
      else $error("option load did not copy accumulator");

   chk_literal_write: assert property ( // [RULE7]
      @(posedge CLK_SYS) disable iff (RST)
      (CE && cls_r == CL_LIT && cyc_r == CYC_FIRST && phase_r == PH_Q3)
      |=> (w_we_r && pc_load_r && w_data_r == $past(ir_r[DW-1:0])))
      else $error("literal return write wrong");

   chk_idle_quiet: assert property ( // [RULE8]
      @(posedge CLK_SYS) disable iff (RST)
      (cyc_r == CYC_IDLE) |-> !(w_we_r || opt_we_r || pc_load_r || gie_set_r))
      else $error("activity in idle cycle");

   chk_ret_no_flags: assert property ( // [RULE9]
      @(posedge CLK_SYS) disable iff (RST)
      (cls_r == CL_RET) |-> !(w_we_r || opt_we_r || gie_set_r))
      else $error("subroutine return wrote state");

   chk_idle_length: assert property ( // [RULE10]
      @(posedge CLK_SYS) disable iff (RST)
      idle_cnt_r <= 3'h4)
      else $error("idle cycle longer than four phases");

   chk_prefetch_drop: assert property ( // [RULE11]
      @(posedge CLK_SYS) disable iff (RST)
      FLUSH_PREFETCH |-> !FETCH_TAKE)
      else $error("word taken during flush");
endmodule
`default_nettype wire

// file: hw/ret_stack_mem_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import ret_ctrl_pkg::*;
;
   logic          CLK_SYS;
   logic          RST;
   logic          CE;
   logic          INSTR_VALID;
   logic [IW-1:0] INSTR;
   logic [DW-1:0] W_IN;
   pc_wr_t        PUSH;
   logic          FETCH_TAKE;
   logic          FLUSH_PREFETCH;
   logic [1:0]    PHASE;
   wr8_t          W_WR;
   wr8_t          OPT_WR;
   pc_wr_t        PC_WR;
   logic [DW-1:0] IRQ_CTRL_SET;
   logic [SPW-1:0] STACK_PTR;
   int n_mismatch = 0;
   int num_checks = 0;
   int m_ph, m_sp, n_fetch, push_bias;
   bit m_idle, started;
   logic [IW-1:0] m_ir;
   logic [DW-1:0] m_w;
   logic [PCW-1:0] stk [8];
   bit vld [8];

   return_ctrl u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .INSTR_VALID(INSTR_VALID),
      .INSTR(INSTR), .W_IN(W_IN), .PUSH(PUSH), .FETCH_TAKE(FETCH_TAKE),
      .FLUSH_PREFETCH(FLUSH_PREFETCH), .PHASE(PHASE), .W_WR(W_WR), .OPT_WR(OPT_WR),
      .PC_WR(PC_WR), .IRQ_CTRL_SET(IRQ_CTRL_SET), .STACK_PTR(STACK_PTR));

   // ------------------------------------------------------------
   // Clock
   // ------------------------------------------------------------
   initial
   begin
      CLK_SYS = 1'b0;
      forever #12.5 CLK_SYS = ~CLK_SYS;
   end

   function automatic bit is_lit(logic [IW-1:0] i);
      return (i & 14'h3C00) == 14'h3400;
   endfunction

   function automatic bit is_ret(logic [IW-1:0] i);
      return i == 14'h0009 || i == 14'h0008 || is_lit(i);
   endfunction

   // ------------------------------------------------------------
   // Reference model, one step per clock edge
   // ------------------------------------------------------------
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         m_ph = 0;
         m_idle = 0;
         m_sp = 0;
         m_ir = 14'h0000;
         started = 1;
         foreach (vld[i]) vld[i] = 0;
      end
      else if (CE)
      begin
         if (m_ph == 0 && !m_idle)
         begin
            m_ir = INSTR_VALID ? INSTR : 14'h0000;
            n_fetch++;
         end
         if (m_ph == 2) m_w = W_IN;
         if (m_ph == 3)
         begin
            // Pop wins over a push in the same slot
            if (!m_idle && is_ret(m_ir))
            begin
               m_sp = (m_sp + 7) % 8;
               m_idle = 1;
            end
            else
            begin
               if (PUSH.load)
               begin
                  stk[m_sp] = PUSH.addr;
                  vld[m_sp] = 1;
                  m_sp = (m_sp + 1) % 8;
               end
               m_idle = 0;
            end
         end
         m_ph = (m_ph + 1) % 4;
      end
   end

   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ------------------------------------------------------------
   // Compare on the falling edge, outputs settled
   // ------------------------------------------------------------
   always @(negedge CLK_SYS)
   begin
      bit q4;
      int hd;
      q4 = (m_ph == 3) && !m_idle;
      hd = (m_sp + 7) % 8;
      if (started)
      begin
         chk("phase", PHASE, (m_ph == 2) ? 3 : (m_ph == 3) ? 2 : m_ph);
         chk("fetch", FETCH_TAKE, m_ph == 0 && !m_idle);
         chk("flush", FLUSH_PREFETCH, m_idle);
         chk("irq_set", IRQ_CTRL_SET, (m_ph == 2 && !m_idle && m_ir == 14'h0009) ? 8'h80 : 0);
         chk("w_we", W_WR.we, q4 && is_lit(m_ir));
         if (q4 && is_lit(m_ir)) chk("w_data", W_WR.data, m_ir[7:0]);
         chk("opt_we", OPT_WR.we, q4 && m_ir == 14'h0062);
         if (q4 && m_ir == 14'h0062) chk("opt_data", OPT_WR.data, m_w);
         chk("pc_load", PC_WR.load, q4 && is_ret(m_ir));
         if (q4 && is_ret(m_ir) && vld[hd]) chk("pc_addr", PC_WR.addr, stk[hd]);
         chk("stack_ptr", STACK_PTR, m_sp);
      end
   end

   // ------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------
   task automatic step(bit r, bit ce, bit v, logic [IW-1:0] ins);
      @(posedge CLK_SYS);
      #1;
      RST = r;
      CE = ce;
      INSTR_VALID = v;
      INSTR = ins;
      W_IN = DW'($urandom);
      PUSH.addr = PCW'($urandom);
      // Push during the idle half of a return is left undefined
      PUSH.load = !m_idle && (($urandom % 4) < push_bias);
   endtask

   task automatic issue(logic [IW-1:0] ins);
      int f0;
      f0 = n_fetch;
      for (int k = 0; k < 40 && n_fetch == f0; k++) step(0, 1, 1, ins);
      chk("fetch_taken", n_fetch != f0, 1'b1);
   endtask

   function automatic logic [IW-1:0] pick();
      case ($urandom % 8)
         0: return IW'(($urandom % 4) << 5);
         1: return 14'h0009;
         2: return 14'h0008;
         3: return 14'h0062;
         4: return 14'h3400 | IW'($urandom % 1024);
         default: return IW'($urandom);
      endcase
   endfunction

   task automatic run_rand(int n);
      repeat (n) step(0, ($urandom % 8) != 0, ($urandom % 8) != 0, pick());
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_mismatch++;
      print_verdict();
   end

   logic [IW-1:0] dir [12] = '{14'h0000, 14'h0020, 14'h0040, 14'h0060, 14'h0009, 14'h0008,
      14'h34A5, 14'h3B5A, 14'h0062, 14'h0062, 14'h0100, 14'h1FFF};

   initial
   begin
      RST = 1'b1;
      CE = 1'b1;
      INSTR_VALID = 1'b0;
      INSTR = 14'h0000;
      W_IN = 8'h00;
      PUSH = '0;
      void'($urandom(63061));
      push_bias = 0;
      repeat (5) step(1, 1, 0, 14'h0000);
      // Fill three entries first so the first three pops have a known head
      push_bias = 4;
      for (int i = 0; i < 4; i++) issue(dir[i]);
      push_bias = 1;
      for (int i = 4; i < 12; i++) issue(dir[i]);
      repeat (8) step(0, 1, 0, 14'h0009);
      $display("test directed done");
      push_bias = 2;
      run_rand(3000);
      $display("test random done");
      run_rand(13);
      repeat (2) step(1, 1, 1, 14'h0009);
      run_rand(600);
      $display("test reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
